// *** logic/mul_defs.svh ***
// constants of the pipelined signed multiplier
`ifndef MUL_DEFS_SVH
`define MUL_DEFS_SVH
`define MUL_OPW 18
`define MUL_PRW 36
`define MUL_AW 12
`define MUL_DW 32
`define MUL_WFW 5
`define MUL_MASK_ALL 18'h3_ffff
`define MUL_OP_MIN 18'h2_0000
`define MUL_PR_MIN2 36'h4_0000_0000
`define MUL_PR_2P35 36'h8_0000_0000
`define MUL_CTRL_OFS 12'h000
`define MUL_OPA_OFS 12'h004
`define MUL_OPB_OFS 12'h008
`define MUL_PLO_OFS 12'h00c
`define MUL_PHI_OFS 12'h010
`define MUL_CTRL_RST 32'h0000_0000
`define MUL_CTRL_WMASK 32'h001f_1f7f
`define MUL_F_CLK_POL 0
`define MUL_F_CEA_POL 1
`define MUL_F_CEB_POL 2
`define MUL_F_CEP_POL 3
`define MUL_F_RSA_POL 4
`define MUL_F_RSB_POL 5
`define MUL_F_RSP_POL 6
`define MUL_F_AW_LO 8
`define MUL_F_AW_HI 12
`define MUL_F_BW_LO 16
`define MUL_F_BW_HI 20
`define MUL_PHI_LO 32
`endif

// *** logic/mul_pkg.sv ***
// types and shared decode functions of the pipelined signed multiplier
`include "mul_defs.svh"
package mul_pkg;
    typedef logic [`MUL_OPW-1:0] mul_opnd_t;
    typedef logic [`MUL_PRW-1:0] mul_prod_t;
    typedef logic [`MUL_DW-1:0] mul_word_t;

    // configured polarity: 0 keeps the pin active high, 1 inverts it
    function automatic logic mul_level(input logic raw, input logic pol);
        return raw ^ pol;
    endfunction

    // keeps the low w operand bits; 0 or anything from 18 up keeps all
    function automatic mul_opnd_t mul_wmask(input logic [`MUL_WFW-1:0] w);
        logic [`MUL_WFW-1:0] sh;
        sh = 5'(`MUL_OPW) - w;
        if (w == '0 || w >= 5'(`MUL_OPW)) begin
            return `MUL_MASK_ALL;
        end
        return `MUL_MASK_ALL >> sh;
    endfunction
endpackage

// *** logic/mul_pipe_stage.sv ***
// one optional pipeline register with its own enable and synchronous reset
`timescale 1ns/1ps
module mul_pipe_stage
    import mul_pkg::*;
#(
    parameter int W = 18,
    parameter bit INSERT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic ce_raw,
    input wire logic ce_pol,
    input wire logic rst_raw,
    input wire logic rst_pol,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    generate
        if (INSERT) begin : g_reg
            logic [W-1:0] stage_q;
            logic [W-1:0] stage_d;
            // reset wins over the enable; nothing moves without an active edge
            always_comb begin
                stage_d = stage_q;
                if (tick) begin
                    if (mul_level(rst_raw, rst_pol)) begin
                        stage_d = '0;
                    end else if (mul_level(ce_raw, ce_pol)) begin
                        stage_d = d;
                    end
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_q <= '0;
                end else begin
                    stage_q <= stage_d;
                end
            end
            assign q = stage_q;
        end else begin : g_wire
            assign q = d;
        end
    endgenerate
endmodule // mul_pipe_stage

// *** logic/mul_pipe_mult.sv ***
// 18x18 signed multiplier with optional stages and an apb control slave
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "mul_defs.svh"
module mul_pipe_mult
    import mul_pkg::*;
#(
    parameter bit A_INSERT = 1'b1,
    parameter bit B_INSERT = 1'b1,
    parameter bit P_INSERT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MUL_AW-1:0] paddr,
    input wire logic [`MUL_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [`MUL_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stage_clk,
    input wire logic [`MUL_OPW-1:0] opnd_a,
    input wire logic [`MUL_OPW-1:0] opnd_b,
    input wire logic ce_a,
    input wire logic ce_b,
    input wire logic ce_p,
    input wire logic rst_a,
    input wire logic rst_b,
    input wire logic rst_p,
    output logic [`MUL_PRW-1:0] product
);
    // ---------------- apb slave ----------------
    mul_word_t ctrl_q;
    mul_word_t ctrl_d;
    mul_word_t prdata_q;
    mul_word_t prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic setup;
    logic commit;
    logic mapped;
    mul_word_t rd_mux;
    mul_word_t strb_mask;

    mul_opnd_t a_op;
    mul_opnd_t b_op;
    mul_prod_t p_out;
    mul_prod_t prod_q;
    mul_prod_t prod_d;

    function automatic logic mul_hit(input logic [`MUL_AW-1:0] a);
        return a == `MUL_CTRL_OFS || a == `MUL_OPA_OFS || a == `MUL_OPB_OFS
            || a == `MUL_PLO_OFS || a == `MUL_PHI_OFS;
    endfunction

    assign setup = psel && !penable;
    assign mapped = mul_hit(paddr);
    // the write lands on the edge where the master sees pready high
    assign commit = psel && penable && pready_q && pwrite && paddr == `MUL_CTRL_OFS;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign strb_mask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate

    always_comb begin
        rd_mux = '0;
        case (paddr)
            `MUL_CTRL_OFS: rd_mux = ctrl_q;
            `MUL_OPA_OFS: rd_mux = {{(`MUL_DW-`MUL_OPW){1'b0}}, a_op};
            `MUL_OPB_OFS: rd_mux = {{(`MUL_DW-`MUL_OPW){1'b0}}, b_op};
            `MUL_PLO_OFS: rd_mux = prod_q[`MUL_DW-1:0];
            `MUL_PHI_OFS: rd_mux = {{(2*`MUL_DW-`MUL_PRW){1'b0}},
                prod_q[`MUL_PRW-1:`MUL_PHI_LO]};
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (commit) begin
            ctrl_d = (ctrl_q & ~(strb_mask & `MUL_CTRL_WMASK))
                | (pwdata & strb_mask & `MUL_CTRL_WMASK);
        end
        pready_d = setup;
        pslverr_d = setup && !mapped;
        prdata_d = '0;
        if (setup && !pwrite) begin
            prdata_d = rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `MUL_CTRL_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- stage clock edge ----------------
    logic clk_lvl;
    logic clk_prev_q;
    logic clk_prev_d;
    logic tick;

    // the stage clock pin is sampled; its active edge becomes a one-cycle tick
    assign clk_lvl = mul_level(stage_clk, ctrl_q[`MUL_F_CLK_POL]);
    assign tick = clk_lvl && !clk_prev_q;

    always_comb begin
        clk_prev_d = clk_lvl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // ---------------- operand path ----------------
    mul_opnd_t a_msk;
    mul_opnd_t b_msk;
    logic signed [`MUL_PRW-1:0] core;

    // bits above the configured width are forced to zero
    assign a_msk = opnd_a & mul_wmask(ctrl_q[`MUL_F_AW_HI:`MUL_F_AW_LO]);
    assign b_msk = opnd_b & mul_wmask(ctrl_q[`MUL_F_BW_HI:`MUL_F_BW_LO]);

    mul_pipe_stage #(
        .W(`MUL_OPW),
        .INSERT(A_INSERT)
    ) u_first_operand_stage (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .ce_raw(ce_a),
        .ce_pol(ctrl_q[`MUL_F_CEA_POL]),
        .rst_raw(rst_a),
        .rst_pol(ctrl_q[`MUL_F_RSA_POL]),
        .d(a_msk),
        .q(a_op)
    );

    mul_pipe_stage #(
        .W(`MUL_OPW),
        .INSERT(B_INSERT)
    ) u_second_operand_stage (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .ce_raw(ce_b),
        .ce_pol(ctrl_q[`MUL_F_CEB_POL]),
        .rst_raw(rst_b),
        .rst_pol(ctrl_q[`MUL_F_RSB_POL]),
        .d(b_msk),
        .q(b_op)
    );

    // full-precision signed product, no bit dropped
    assign core = $signed(a_op) * $signed(b_op);

    mul_pipe_stage #(
        .W(`MUL_PRW),
        .INSERT(P_INSERT)
    ) u_product_output_stage (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .ce_raw(ce_p),
        .ce_pol(ctrl_q[`MUL_F_CEP_POL]),
        .rst_raw(rst_p),
        .rst_pol(ctrl_q[`MUL_F_RSP_POL]),
        .d(core),
        .q(p_out)
    );

    // output flop retimes the product onto pclk; one pclk of extra delay
    always_comb begin
        prod_d = p_out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prod_q <= '0;
        end else begin
            prod_q <= prod_d;
        end
    end

    assign product = prod_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic cea_on;
    logic rsa_on;
    logic cep_on;
    logic rsp_on;
    assign cea_on = mul_level(ce_a, ctrl_q[`MUL_F_CEA_POL]);
    assign rsa_on = mul_level(rst_a, ctrl_q[`MUL_F_RSA_POL]);
    assign cep_on = mul_level(ce_p, ctrl_q[`MUL_F_CEP_POL]);
    assign rsp_on = mul_level(rst_p, ctrl_q[`MUL_F_RSP_POL]);

    sequence s_p_load;
        tick && cep_on && !rsp_on;
    endsequence

    sequence s_p_quiet;
        !tick;
    endsequence

    generate
        if (P_INSERT) begin : g_chk_p
            a_prod_exact: assert property (
                s_p_load ##1 s_p_quiet |=> prod_q == $past(core, 2))
                else $error("registered product differs from operand product");
            a_prod_hold: assert property (
                s_p_quiet ##1 s_p_quiet |-> ##1 $stable(prod_q))
                else $error("product moved without an active stage edge");
        end else begin : g_chk_pc
            a_prod_exact: assert property (
                1'b1 |=> prod_q == $past(core))
                else $error("combinational product path wrong");
        end
        if (A_INSERT) begin : g_chk_a
            a_stage_clear: assert property (
                tick && rsa_on |=> a_op == '0)
                else $error("first operand stage did not clear");
            a_stage_load: assert property (
                tick && cea_on && !rsa_on |=> a_op == $past(a_msk))
                else $error("first operand stage did not load");
            a_stage_hold: assert property (
                !tick || (!cea_on && !rsa_on) |=> $stable(a_op))
                else $error("first operand stage changed while idle");
        end else begin : g_chk_ab
            a_bypass_path: assert property (
                a_op == a_msk)
                else $error("bypassed operand path not transparent");
        end
    endgenerate

    a_range_min: assert property (
        a_op == `MUL_OP_MIN && b_op == `MUL_OP_MIN |-> core == `MUL_PR_MIN2)
        else $error("most negative squared gives wrong product");
    a_msb_zero: assert property (
        !a_op[`MUL_OPW-1] && !b_op[`MUL_OPW-1] && core < `MUL_PR_2P35
        |-> !core[`MUL_PRW-1])
        else $error("top product bit set for small unsigned product");
    a_sign_dup: assert property (
        !(a_op == `MUL_OP_MIN && b_op == `MUL_OP_MIN)
        |-> core[`MUL_PRW-1] == core[`MUL_PRW-2])
        else $error("top two product bits disagree");
    a_width_mask: assert property (
        ctrl_q[`MUL_F_AW_HI:`MUL_F_AW_LO] == 5'h8 |-> a_msk[`MUL_OPW-1:8] == '0)
        else $error("unused operand bits not zero");
    a_tick_edge: assert property (
        tick |-> clk_lvl && !$past(clk_lvl))
        else $error("stage tick without active edge");
    a_apb_ready: assert property (
        setup |=> pready_q ##1 !pready_q || setup)
        else $error("apb ready not one access cycle");
endmodule // mul_pipe_mult

// *** dv/mul_user_model.sv ***
// surrounding user logic model: makes the stage clock of the multiplier
`timescale 1ns/1ps
module mul_user_model #(
    parameter int HALF = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic stage_clk,
    output logic [7:0] rises
);
    logic [3:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            stage_clk <= 1'b0;
            rises <= 8'h00;
        end else if (cnt_q == 4'(HALF - 1)) begin
            cnt_q <= 4'h0;
            stage_clk <= ~stage_clk;
            rises <= rises + 8'(!stage_clk);
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // mul_user_model

// *** dv/mul_pipe_mult_tb.sv ***
// self-checking bench for the pipelined signed multiplier
`timescale 1ns/1ps
`include "mul_defs.svh"
module mul_pipe_mult_tb;
    import mul_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    mul_word_t prdata;
    logic pready;
    logic pslverr;
    logic stage_clk;
    logic [7:0] rises;
    mul_opnd_t opnd_a = '0;
    mul_opnd_t opnd_b = '0;
    logic ce_a = 1'b1, ce_b = 1'b1, ce_p = 1'b1;
    logic rst_a = 1'b0, rst_b = 1'b0, rst_p = 1'b0;
    mul_prod_t product;
    mul_prod_t product_c;
    logic chk = 1'b0;
    logic [35:0] notes[$];
    int n_errors = 0;
    int compares = 0;

    always #12.5 pclk = ~pclk;

    mul_pipe_mult dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .stage_clk, .opnd_a, .opnd_b, .ce_a, .ce_b,
        .ce_p, .rst_a, .rst_b, .rst_p, .product);
    // every stage removed: combinational paths up to the output flop on pclk
    mul_pipe_mult #(.A_INSERT(1'b0), .B_INSERT(1'b0), .P_INSERT(1'b0)) dut_c (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(),
        .pready(), .pslverr(), .stage_clk, .opnd_a, .opnd_b, .ce_a, .ce_b, .ce_p, .rst_a,
        .rst_b, .rst_p, .product(product_c));
    mul_user_model user_u (.pclk, .presetn, .stage_clk, .rises);

    function automatic mul_prod_t prod(input mul_opnd_t a, input mul_opnd_t b);
        logic signed [35:0] x, y;
        x = $signed(a);
        y = $signed(b);
        return x * y;
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // for reads d is the expected {pslverr, prdata}
    task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] d);
        int i;
        if (!wr) notes.push_back({3'b000, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d[31:0];
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
        if (i == 50) begin
            n_errors++;
            results();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle keeps a following setup from rewriting psel in this step
        @(posedge pclk);
    endtask

    task automatic settle(input mul_prod_t eu, input mul_prod_t ec);
        logic [7:0] r0;
        int i;
        r0 = rises;
        for (i = 0; i < 100 && 8'(rises - r0) < 8'h03; i++) @(posedge pclk);
        if (i == 100) begin
            n_errors++;
            results();
        end
        repeat (2) @(posedge pclk);
        notes.push_back(eu);
        notes.push_back(ec);
        chk <= 1'b1;
        @(posedge pclk);
        chk <= 1'b0;
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            check({3'b000, pslverr, prdata}, notes.pop_front());
        end
        if (chk) begin
            check(product, notes.pop_front());
            check(product_c, notes.pop_front());
        end
    end

    initial begin
        mul_opnd_t a, b, pa, pb;
        static mul_opnd_t ca[6] = '{18'h2_0000, 18'h2_0000, 18'h1_ffff, 18'h3_ffff,
            18'h0_0000, 18'h1_ffff};
        static mul_opnd_t cb[6] = '{18'h2_0000, 18'h1_ffff, 18'h1_ffff, 18'h3_ffff,
            18'h3_ffff, 18'h3_ffff};
        void'($urandom(32'h5f3f_2f08));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `MUL_CTRL_OFS, {1'b0, `MUL_CTRL_RST});
        apb(1'b0, `MUL_PLO_OFS, 33'h0_0000_0000);
        apb(1'b0, 12'h014, 33'h1_0000_0000);
        for (int i = 0; i < 14; i++) begin
            a = (i < 6) ? ca[i] : mul_opnd_t'($urandom);
            b = (i < 6) ? cb[i] : mul_opnd_t'($urandom);
            opnd_a <= a;
            opnd_b <= b;
            settle(prod(a, b), prod(a, b));
            apb(1'b0, `MUL_PLO_OFS, {1'b0, 32'(prod(a, b))});
            apb(1'b0, `MUL_PHI_OFS, {29'h0, 4'(prod(a, b) >> 32)});
        end
        pa = a;
        pb = b;
        for (int s = 0; s < 3; s++) begin
            a = mul_opnd_t'($urandom);
            b = mul_opnd_t'($urandom);
            {ce_p, ce_b, ce_a} <= ~(3'b001 << s);
            opnd_a <= a;
            opnd_b <= b;
            settle(s == 2 ? prod(pa, pb) : prod(s == 0 ? pa : a, s == 1 ? pb : b),
                prod(a, b));
            {ce_p, ce_b, ce_a} <= 3'b111;
            {rst_p, rst_b, rst_a} <= 3'b001 << s;
            settle('0, prod(a, b));
            {rst_p, rst_b, rst_a} <= 3'b000;
            settle(prod(a, b), prod(a, b));
            pa = a;
            pb = b;
        end
        apb(1'b1, `MUL_CTRL_OFS, 33'h0_0000_007f);
        {ce_p, ce_b, ce_a} <= 3'b000;
        {rst_p, rst_b, rst_a} <= 3'b111;
        a = mul_opnd_t'($urandom);
        opnd_a <= a;
        settle(prod(a, pb), prod(a, pb));
        ce_a <= 1'b1;
        opnd_a <= pa;
        settle(prod(a, pb), prod(pa, pb));
        rst_p <= 1'b0;
        settle('0, prod(pa, pb));
        apb(1'b1, `MUL_CTRL_OFS, 33'h0_ffff_ffff);
        apb(1'b0, `MUL_CTRL_OFS, {1'b0, `MUL_CTRL_WMASK});
        apb(1'b1, `MUL_CTRL_OFS, 33'h0_0004_0800);
        {ce_p, ce_b, ce_a} <= 3'b111;
        {rst_p, rst_b, rst_a} <= 3'b000;
        opnd_a <= 18'h2_05a5;
        opnd_b <= 18'h3_fffb;
        settle(prod(18'h0_00a5, 18'h0_000b), prod(18'h0_00a5, 18'h0_000b));
        results();
    end
endmodule // mul_pipe_mult_tb
